// >>> hw/fsd_pkg.sv
// How it works
// - Fault bits read-only, cleared by any fault register read.
// - Fault register cleared on system or local reset.
// - Fault bits 31 to 15 read as ones.
// - Unmapped local access sets bit, raises fault.
// - Parity bit set on enabled slave-read errors.
// - That parity error also asserts bus error.
// - Master bus error sets bit, faults one cycle later.
// - Four sticky processor-bus error bits, one per processor.
// - Absent processors' error bits always read zero.
// - Four sticky data cache-unit error bits.
// - Four sticky code cache-unit error bits.
// - Two 4-bit decoder registers, cleared on reset.
// - Config 1: A steers cpu0, B cpu1.
// - Config 2: A steers code, B data.
// - Config 6: A steers both, B unused.
// - Configs 0, 5, A: no decoder effect.
// - Code 00 address interleave, 01 supervisor split.
// - Codes 10/11: supervisor or shared SRAM unit.
// - Config 1: bits 3:2 code, 1:0 data.
// - Undefined register bits read one, ignored on writes; unmapped offsets read zero.
`default_nettype none

package fsd_pkg;

   // ==========================================================
   // Register map.
   localparam logic [7:0] FAULT_CAUSE_OFS = 8'h00;
   localparam logic [7:0] DEC_A_CFG_OFS = 8'h04;
   localparam logic [7:0] DEC_B_CFG_OFS = 8'h08;
   localparam logic [7:0] CTRL_OFS = 8'h0c;

   // ==========================================================
   // Field positions and reset values.
   localparam int UNMAPPED_BIT = 14;
   localparam int PARITY_BIT = 13;
   localparam int VME_ERR_BIT = 12;
   localparam int PBUS_LSB = 8;
   localparam int DMMU_LSB = 4;
   localparam int CACHE_MMU_LSB = 0;
   localparam int PARITY_ERR_ENABLE_BIT = 0;
   localparam logic [16:0] FAULT_ONES = 17'h1ffff;
   localparam logic [3:0] DEC_CFG_RST = 4'h0;
   localparam logic [14:0] FAULT_RST = 15'h0000;

   // ==========================================================
   // Module configurations and pair codes.
   localparam logic [3:0] CFG_QUAD = 4'h0;
   localparam logic [3:0] CFG_DUAL_P = 4'h1;
   localparam logic [3:0] CFG_ONE_8 = 4'h2;
   localparam logic [3:0] CFG_DUAL = 4'h5;
   localparam logic [3:0] CFG_ONE_4 = 4'h6;
   localparam logic [3:0] CFG_SINGLE = 4'ha;

   typedef enum logic [1:0] {
      SEL_ADDR_ILV = 2'h0,
      SEL_SUPV_SPLIT = 2'h1,
      SEL_SUPV_SRAM = 2'h2,
      SEL_SHARED_SRAM = 2'h3
   } fsd_sel_type;

   // Selection methods for the four code and four data cache pairs.
   typedef struct packed {
      logic active;
      fsd_sel_type [3:0] code_sel;
      fsd_sel_type [3:0] data_sel;
   } fsd_map_type;

   // Error events from the surrounding board, one-cycle pulses.
   typedef struct packed {
      logic unmapped_local_addr;
      logic slave_read_parity;
      logic vme_master_err;
      logic [3:0] proc_bus_err;
      logic [3:0] data_mmu_err;
      logic [3:0] code_mmu_err;
   } fsd_evt_type;

endpackage

`default_nettype wire

// >>> hw/fsd_regs.sv
// Local design decisions: the register addresses and register access over AHB-Lite.
`default_nettype none

module fsd_regs (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic system_reset,
   input wire logic local_reset,
   input wire logic [3:0] config_identity,
   input wire fsd_pkg::fsd_evt_type evt,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic mbus_fault,
   output logic vme_berr,
   output fsd_pkg::fsd_map_type dec_map
);

   // ==========================================================
   // Reset synchronisers and identity sampling.
   logic [1:0] sr_s_r;
   logic [1:0] lr_s_r;
   logic [3:0] id_m_r;
   logic [3:0] id_r;
   logic clr_all;

   // System reset pin: two flops, and only the second one is read by logic.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sr_s_r <= 2'h0;
      end else begin
         sr_s_r <= {sr_s_r[0], system_reset};
      end
   end

   // Local reset pin: synchronised in the same way as the system reset.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lr_s_r <= 2'h0;
      end else begin
         lr_s_r <= {lr_s_r[0], local_reset};
      end
   end

   // Identity pins are a static strap, but a slow edge must not split the code.
   // A change of strap reaches the decoder three clocks after the pins move.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         id_m_r <= 4'h0;
         id_r <= 4'h0;
      end else begin
         id_m_r <= config_identity;
         id_r <= id_m_r;
      end
   end

   // Either synchronised reset request clears the software-visible state.
   // The pins are sampled, so a request shorter than one clock may be missed.
   assign clr_all = sr_s_r[1] | lr_s_r[1];

   // ==========================================================
   // Bus address phase capture.
   logic wr_ph_r;
   logic rd_ph_r;
   logic [7:0] ofs_r;
   logic accept;

   assign accept = hsel & htrans[1] & hready;

   // Marks the data phase of an accepted transfer; every answer is zero-wait.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ph_r <= 1'b0;
         rd_ph_r <= 1'b0;
      end else begin
         wr_ph_r <= accept & hwrite;
         rd_ph_r <= accept & ~hwrite;
      end
   end

   // Offset of the transfer, only meaningful while a phase flag is set.
   // Only the low address byte is decoded, so the map repeats above it.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ofs_r <= 8'h00;
      end else begin
         ofs_r <= haddr[7:0];
      end
   end

   // The slave never inserts a wait state.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hreadyout <= 1'b1;
      end else begin
         hreadyout <= 1'b1;
      end
   end

   // Every transfer ends with an OKAY response.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // ==========================================================
   // Writable registers.
   logic [3:0] dec_a_r;
   logic [3:0] dec_a_nxt;
   logic [3:0] dec_b_r;
   logic [3:0] dec_b_nxt;
   logic parity_err_enable_r;
   logic parity_err_enable_nxt;
   logic wr_dec_a;
   logic wr_dec_b;
   logic wr_ctrl;

   // Write strobes, one per register, valid in the data phase.
   assign wr_dec_a = wr_ph_r & (ofs_r == fsd_pkg::DEC_A_CFG_OFS);
   assign wr_dec_b = wr_ph_r & (ofs_r == fsd_pkg::DEC_B_CFG_OFS);
   assign wr_ctrl = wr_ph_r & (ofs_r == fsd_pkg::CTRL_OFS);

   // Next value of decoder register A; a reset request beats a write.
   // Writes are stored in every configuration, even where no decoder exists.
   always_comb begin
      dec_a_nxt = dec_a_r;
      if (clr_all) begin
         dec_a_nxt = fsd_pkg::DEC_CFG_RST;
      end else if (wr_dec_a) begin
         dec_a_nxt = hwdata[3:0];
      end
   end

   // Next value of decoder register B; the upper write bits are dropped.
   always_comb begin
      dec_b_nxt = dec_b_r;
      if (clr_all) begin
         dec_b_nxt = fsd_pkg::DEC_CFG_RST;
      end else if (wr_dec_b) begin
         dec_b_nxt = hwdata[3:0];
      end
   end

   // Next value of the parity-error enable; it starts disabled.
   always_comb begin
      parity_err_enable_nxt = parity_err_enable_r;
      if (clr_all) begin
         parity_err_enable_nxt = 1'b0;
      end else if (wr_ctrl) begin
         parity_err_enable_nxt = hwdata[fsd_pkg::PARITY_ERR_ENABLE_BIT];
      end
   end

   // Decoder register A.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dec_a_r <= fsd_pkg::DEC_CFG_RST;
      end else begin
         dec_a_r <= dec_a_nxt;
      end
   end

   // Decoder register B.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dec_b_r <= fsd_pkg::DEC_CFG_RST;
      end else begin
         dec_b_r <= dec_b_nxt;
      end
   end

   // Parity-error enable flag.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         parity_err_enable_r <= 1'b0;
      end else begin
         parity_err_enable_r <= parity_err_enable_nxt;
      end
   end

   // ==========================================================
   // Fault cause register.
   logic [14:0] fault_r;
   logic [14:0] set_v;
   logic [14:0] fault_nxt;
   logic [3:0] pmask;
   logic fault_rd;
   logic par_hit;

   // Processor bits that the installed module cannot have are held at zero.
   always_comb begin
      pmask = 4'hf;
      if (id_r == fsd_pkg::CFG_DUAL_P || id_r == fsd_pkg::CFG_DUAL) begin
         pmask = 4'h3;
      end else if (id_r == fsd_pkg::CFG_ONE_8 || id_r == fsd_pkg::CFG_ONE_4
                   || id_r == fsd_pkg::CFG_SINGLE) begin
         pmask = 4'h1;
      end
   end

   assign par_hit = evt.slave_read_parity & parity_err_enable_r;
   assign fault_rd = rd_ph_r & (ofs_r == fsd_pkg::FAULT_CAUSE_OFS);

   always_comb begin
      set_v = fsd_pkg::FAULT_RST;
      set_v[fsd_pkg::UNMAPPED_BIT] = evt.unmapped_local_addr;
      set_v[fsd_pkg::PARITY_BIT] = par_hit;
      set_v[fsd_pkg::VME_ERR_BIT] = evt.vme_master_err;
      set_v[fsd_pkg::PBUS_LSB +: 4] = evt.proc_bus_err & pmask;
      set_v[fsd_pkg::DMMU_LSB +: 4] = evt.data_mmu_err;
      set_v[fsd_pkg::CACHE_MMU_LSB +: 4] = evt.code_mmu_err;
   end

   // Next value of the sticky cause bits.
   // A new event in the cycle of the clearing read survives the clear.
   always_comb begin
      fault_nxt = fault_r | set_v;
      if (clr_all) begin
         fault_nxt = fsd_pkg::FAULT_RST;
      end else if (fault_rd) begin
         fault_nxt = set_v;
      end
   end

   // Cause bits; software has no write path to them.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_r <= fsd_pkg::FAULT_RST;
      end else begin
         fault_r <= fault_nxt;
      end
   end

   // Memory-bus fault: raised after an unmapped or master error event,
   // and held for as long as the unmapped bit stays set.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mbus_fault <= 1'b0;
      end else begin
         mbus_fault <= evt.vme_master_err | evt.unmapped_local_addr
                       | (fault_r[fsd_pkg::UNMAPPED_BIT] & ~fault_rd & ~clr_all);
      end
   end

   // Slave bus error: one cycle for each enabled parity error on a slave read.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         vme_berr <= 1'b0;
      end else begin
         vme_berr <= par_hit;
      end
   end

   // ==========================================================
   // Read data, captured at the end of the address phase.
   logic [31:0] rd_word;

   // Word that the addressed register holds after this edge, so that a write
   // or a clearing read that ends at the same edge is already visible.
   always_comb begin
      rd_word = 32'hffffffff;
      case (haddr[7:0])
         fsd_pkg::FAULT_CAUSE_OFS: begin
            rd_word = {fsd_pkg::FAULT_ONES, fault_nxt};
         end
         fsd_pkg::DEC_A_CFG_OFS: begin
            rd_word = {28'hfffffff, dec_a_nxt};
         end
         fsd_pkg::DEC_B_CFG_OFS: begin
            rd_word = {28'hfffffff, dec_b_nxt};
         end
         fsd_pkg::CTRL_OFS: begin
            rd_word = {31'h7fffffff, parity_err_enable_nxt};
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   // The bus sees a flop output that stands for the whole data phase.
   // Events in the data phase are kept for the next read, not shown in this one.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= 32'h00000000;
      end else if (accept & ~hwrite) begin
         hrdata <= rd_word;
      end
   end

   // ==========================================================
   // Decoder mapping steered by configuration.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dec_map <= '0;
      end else begin
         dec_map <= '0;
         case (id_r)
            fsd_pkg::CFG_DUAL_P: begin
               dec_map.active <= 1'b1;
               dec_map.code_sel[0] <= fsd_pkg::fsd_sel_type'(dec_a_r[3:2]);
               dec_map.code_sel[1] <= fsd_pkg::fsd_sel_type'(dec_b_r[3:2]);
               dec_map.data_sel[0] <= fsd_pkg::fsd_sel_type'(dec_a_r[1:0]);
               dec_map.data_sel[1] <= fsd_pkg::fsd_sel_type'(dec_b_r[1:0]);
            end
            fsd_pkg::CFG_ONE_8: begin
               dec_map.active <= 1'b1;
               dec_map.code_sel[0] <= fsd_pkg::fsd_sel_type'(dec_a_r[1:0]);
               dec_map.code_sel[1] <= fsd_pkg::fsd_sel_type'(dec_a_r[3:2]);
               dec_map.data_sel[0] <= fsd_pkg::fsd_sel_type'(dec_b_r[1:0]);
               dec_map.data_sel[1] <= fsd_pkg::fsd_sel_type'(dec_b_r[3:2]);
            end
            fsd_pkg::CFG_ONE_4: begin
               dec_map.active <= 1'b1;
               dec_map.code_sel[0] <= fsd_pkg::fsd_sel_type'(dec_a_r[3:2]);
               dec_map.data_sel[0] <= fsd_pkg::fsd_sel_type'(dec_a_r[1:0]);
            end
            default: begin
               dec_map.active <= 1'b0;
            end
         endcase
      end
   end

endmodule // fsd_regs

`default_nettype wire

// >>> sim/fault_status_and_pbus_decoder_cfg_tb.sv
`default_nettype none
module fault_status_and_pbus_decoder_cfg_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, arst_n, system_reset, local_reset, hsel, hwrite, hready, hreadyout, hresp;
   logic mbus_fault, vme_berr, go;
   logic [3:0] config_identity, a, b, m;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [14:0] r, q;
   logic [16:0] e, msk;
   fsd_pkg::fsd_evt_type evt, req;
   fsd_pkg::fsd_map_type dec_map;
   int failures, num_checks, berrs, pe_exp;
   logic [3:0] cfgs [6] = '{4'h1, 4'h2, 4'h6, 4'h0, 4'h5, 4'ha};
   fsd_regs uut (
      .clk(clk),
      .arst_n(arst_n),
      .system_reset(system_reset),
      .local_reset(local_reset),
      .config_identity(config_identity),
      .evt(evt),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .mbus_fault(mbus_fault),
      .vme_berr(vme_berr),
      .dec_map(dec_map)
   );
   fsd_err_src src (.clk(clk), .go(go), .req(req), .evt(evt));
   assign hready = hreadyout;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Counts bus error cycles seen on the slave side.
   always @(posedge clk) if (vme_berr === 1'b1) berrs++;
   // ==========================================================
   // Bus and check tasks.
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         failures++;
         tally_and_finish();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, ad};
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic pulse(input logic [14:0] v);
      req <= v;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // ==========================================================
   // Main sequence.
   initial begin
      void'($urandom(32'h0c84dafd));
      {arst_n, system_reset, local_reset, go, hsel, hwrite, htrans, haddr, hwdata, req} = '0;
      hsize = 3'h2;
      config_identity = 4'h0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      bus(0, 8'h00, 0);
      chk("fault", 32'hffff8000, rd);
      bus(1, 8'h00, 32'hffffffff);
      bus(0, 8'h00, 0);
      chk("fault_ro", 32'hffff8000, rd);
      bus(0, 8'h04, 0);
      chk("dec_a", 32'hfffffff0, rd);
      bus(1, 8'h0c, 32'h1);
      // Two random error bursts accumulate until a read clears them.
      for (int i = 0; i < 8; i++) begin
         r = 15'($urandom);
         q = 15'($urandom);
         pulse(r);
         pulse(q);
         pe_exp += int'(r[13]) + int'(q[13]);
         bus(0, 8'h00, 0);
         chk("fault_acc", {17'h1ffff, r | q}, rd);
         bus(0, 8'h00, 0);
         chk("fault_clr", 32'hffff8000, rd);
      end
      bus(1, 8'h0c, 32'h0);
      pulse(15'h2000);
      bus(0, 8'h00, 0);
      chk("parity_off", 32'hffff8000, rd);
      chk("berr_count", pe_exp, berrs);
      foreach (cfgs[k]) begin
         config_identity <= cfgs[k];
         repeat (5) @(posedge clk);
         a = 4'($urandom);
         b = 4'($urandom);
         bus(1, 8'h04, {28'($urandom), a});
         bus(1, 8'h08, {28'($urandom), b});
         repeat (2) @(posedge clk);
         case (cfgs[k])
            4'h1: e = {1'b1, 4'h0, b[3:2], a[3:2], 4'h0, b[1:0], a[1:0]};
            4'h2: e = {1'b1, 4'h0, a[3:2], a[1:0], 4'h0, b[3:2], b[1:0]};
            4'h6: e = {1'b1, 6'h0, a[3:2], 6'h0, a[1:0]};
            default: e = 17'h0;
         endcase
         msk = cfgs[k] == 4'h6 ? 17'h10303 : (e[16] ? 17'h10f0f : 17'h10000);
         chk("map", 32'(e), 32'(dec_map & msk));
         bus(0, 8'h08, 0);
         chk("dec_b", {28'hfffffff, b}, rd);
         m = cfgs[k] == 4'h0 ? 4'hf : (cfgs[k] inside {4'h1, 4'h5} ? 4'h3 : 4'h1);
         pulse(15'h5fff);
         chk("mbus_fault", 32'h1, {31'h0, mbus_fault});
         bus(0, 8'h00, 0);
         chk("proc_mask", {17'h1ffff, 15'h5fff & {3'h7, m, 8'hff}}, rd);
      end
      for (int k = 0; k < 2; k++) begin
         bus(1, 8'h04, 32'hf);
         pulse(15'h1fff);
         {system_reset, local_reset} <= k ? 2'b10 : 2'b01;
         repeat (4) @(posedge clk);
         bus(0, 8'h00, 0);
         chk("rst_fault", 32'hffff8000, rd);
         {system_reset, local_reset} <= 2'b00;
         repeat (3) @(posedge clk);
         bus(0, 8'h04, 0);
         chk("rst_dec_a", 32'hfffffff0, rd);
      end
      tally_and_finish();
   end
endmodule // fault_status_and_pbus_decoder_cfg_tb
bind fsd_regs fsd_props chk (
   .clk(clk),
   .arst_n(arst_n),
   .system_reset(system_reset),
   .local_reset(local_reset),
   .config_identity(config_identity),
   .evt(evt),
   .hsel(hsel),
   .haddr(haddr),
   .htrans(htrans),
   .hwrite(hwrite),
   .hsize(hsize),
   .hwdata(hwdata),
   .hready(hready),
   .hrdata(hrdata),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .mbus_fault(mbus_fault),
   .vme_berr(vme_berr),
   .dec_map(dec_map)
);
`default_nettype wire

// >>> sim/fsd_err_src.sv
`default_nettype none
module fsd_err_src (
   input wire logic clk,
   input wire logic go,
   input wire fsd_pkg::fsd_evt_type req,
   output fsd_pkg::fsd_evt_type evt
);
   timeunit 1ns;
   timeprecision 1ps;
   // Board error sources report each fault as a one-cycle pulse in the register clock.
   always_ff @(posedge clk) begin
      evt <= go ? req : '0;
   end
endmodule // fsd_err_src
`default_nettype wire

// >>> sim/fsd_props.sv
`default_nettype none
module fsd_props (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic system_reset,
   input wire logic local_reset,
   input wire logic [3:0] config_identity,
   input wire fsd_pkg::fsd_evt_type evt,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic mbus_fault,
   input wire logic vme_berr,
   input wire fsd_pkg::fsd_map_type dec_map
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rd_f;
   // ==========================================================
   // Marks the data phase of a fault register read.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_f <= 1'b0;
      end else begin
         rd_f <= hsel && htrans[1] && hready && !hwrite && haddr[7:0] == 8'h00;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_vme; evt.vme_master_err |=> mbus_fault; endproperty
   a_vme: assert property (p_vme) else $error("no fault after vme error");
   property p_unm; evt.unmapped_local_addr |=> mbus_fault; endproperty
   a_unm: assert property (p_unm) else $error("no fault after unmapped access");
   property p_berr; vme_berr |-> $past(evt.slave_read_parity); endproperty
   a_berr: assert property (p_berr) else $error("bus error without parity event");
   logic quiet_r;
   // Set by a fault read that saw no event, lost on any later event.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         quiet_r <= 1'b0;
      end else if (rd_f) begin
         quiet_r <= (evt == '0);
      end else if (evt != '0) begin
         quiet_r <= 1'b0;
      end
   end
   property p_rc; rd_f && quiet_r |-> hrdata[14:0] == 15'h0000; endproperty
   a_rc: assert property (p_rc) else $error("fault bits not cleared by read");
   property p_rst; (system_reset || local_reset) [*4] ##0 rd_f |-> hrdata[14:0] == 15'h0000;
   endproperty
   a_rst: assert property (p_rst) else $error("fault bits survive reset");
   property p_on; (config_identity inside {4'h1, 4'h2, 4'h6}) [*5] |-> dec_map.active; endproperty
   a_on: assert property (p_on) else $error("decoder not active");
   property p_off; (config_identity inside {4'h0, 4'h5, 4'ha}) [*5] |-> !dec_map.active;
   endproperty
   a_off: assert property (p_off) else $error("decoder active without decoder");
   property p_pm; (config_identity inside {4'h2, 4'h6, 4'ha}) [*5] ##0 rd_f |-> hrdata[11:9] == 3'h0;
   endproperty
   a_pm: assert property (p_pm) else $error("absent processor bit set");
   c_rd: cover property (rd_f);
   c_berr: cover property (vme_berr);
   c_map: cover property (dec_map.active);
endmodule // fsd_props
`default_nettype wire
